/* design/nalu_pkg.sv */
// Constants, types and decode functions of the nibble ALU
package nalu_pkg;
    localparam int NIB_W = 4;
    localparam int PADDR_W = 12;
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_PSW = 12'h004;
    localparam logic [11:0] OFF_INDEX = 12'h008;
    localparam logic [11:0] OFF_TEMP = 12'h00C;
    localparam logic [11:0] OFF_REG_BASE = 12'h040;
    localparam logic [11:0] OFF_MEM_BASE = 12'h100;
    localparam int REG_COUNT = 16;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_FORM_BIT = 4;
    localparam int CMD_FIRST_LSB = 8;
    localparam int CMD_SECOND_LSB = 16;
    localparam int CMD_FIELD_W = 8;
    localparam int PSW_INDEX_BIT = 0;
    localparam int PSW_ZERO_BIT = 1;
    localparam int PSW_CARRY_BIT = 2;
    localparam int PSW_NOSTORE_BIT = 3;
    localparam int PSW_DECIMAL_BIT = 4;
    localparam int PSW_BUSY_BIT = 5;
    localparam int PSW_SKIP_BIT = 6;
    localparam int PSW_W = 5;
    localparam logic [4:0] PSW_RESET = 5'h00;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [4:0] DEC_LIMIT = 5'h09;
    localparam logic [4:0] DEC_ADJUST = 5'h06;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUM_CARRY, OP_SUB, OP_DIFF_BORROW,
        OP_AND, OP_OR, OP_XOR,
        OP_TEST_TRUE, OP_TEST_FALSE,
        OP_EQ, OP_NE, OP_GE, OP_LT,
        OP_ROTATE_RIGHT_CARRY
    } nalu_op_e;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_EXEC} nalu_state_e;

    function automatic logic is_arith(input nalu_op_e op);
        is_arith = (op == OP_ADD) || (op == OP_SUM_CARRY) || (op == OP_SUB)
            || (op == OP_DIFF_BORROW);
    endfunction

    function automatic logic is_logic(input nalu_op_e op);
        is_logic = (op == OP_AND) || (op == OP_OR) || (op == OP_XOR);
    endfunction

    function automatic logic is_bitchk(input nalu_op_e op);
        is_bitchk = (op == OP_TEST_TRUE) || (op == OP_TEST_FALSE);
    endfunction

    function automatic logic is_check(input nalu_op_e op);
        is_check = is_bitchk(op) || (op == OP_EQ) || (op == OP_NE) || (op == OP_GE)
            || (op == OP_LT);
    endfunction
endpackage

/* design/nalu_alu_if.sv */
// Interface between the ALU sequencer and its combinational core
`timescale 1ns/100ps
interface nalu_alu_if;
    import nalu_pkg::*;
    nalu_op_e op;
    logic [3:0] a;
    logic [3:0] b;
    logic carry_in;
    logic decimal;
    logic [3:0] result;
    logic carry_out;
    logic cond;

    modport core (
        input op, a, b, carry_in, decimal,
        output result, carry_out, cond
    );
    modport ctrl (
        output op, a, b, carry_in, decimal,
        input result, carry_out, cond
    );
endinterface

/* design/nalu_core.sv */
// Combinational nibble ALU core working on the temporary operands
`timescale 1ns/100ps
module nalu_core (
    // Operands and results
    nalu_alu_if.core alu
);
    import nalu_pkg::*;

    logic [4:0] sum5;
    logic [4:0] diff5;
    logic cin;
    logic dec_carry;

    always_comb begin
        cin = ((alu.op == OP_SUM_CARRY) || (alu.op == OP_DIFF_BORROW)) && alu.carry_in; // [RULE15]
        sum5 = {1'b0, alu.a} + {1'b0, alu.b} + {4'h0, cin};
        diff5 = {1'b0, alu.a} - {1'b0, alu.b} - {4'h0, cin};
        alu.result = NIB_ZERO;
        alu.carry_out = 1'b0;
        alu.cond = 1'b0;
        dec_carry = 1'b0;
        case (alu.op)
            OP_ADD, OP_SUM_CARRY: begin
                if (alu.decimal) begin
                    dec_carry = sum5 > DEC_LIMIT; // [RULE19]
                    alu.carry_out = dec_carry;
                    alu.result = dec_carry ? 4'(sum5 + DEC_ADJUST) : sum5[3:0];
                end else begin
                    alu.carry_out = sum5[4]; // [RULE13] [RULE16]
                    alu.result = sum5[3:0];
                end
            end
            OP_SUB, OP_DIFF_BORROW: begin
                if (alu.decimal) begin
                    dec_carry = diff5[4] || (diff5 > DEC_LIMIT); // [RULE19]
                    alu.carry_out = dec_carry;
                    alu.result = dec_carry ? 4'(diff5 - DEC_ADJUST) : diff5[3:0];
                end else begin
                    alu.carry_out = diff5[4]; // [RULE13] [RULE16]
                    alu.result = diff5[3:0];
                end
            end
            OP_AND: alu.result = alu.a & alu.b;
            OP_OR: alu.result = alu.a | alu.b;
            OP_XOR: alu.result = alu.a ^ alu.b;
            OP_TEST_TRUE: alu.cond = (alu.a & alu.b) == alu.b;
            OP_TEST_FALSE: alu.cond = (alu.a & alu.b) == NIB_ZERO;
            OP_EQ: alu.cond = alu.a == alu.b;
            OP_NE: alu.cond = alu.a != alu.b;
            OP_GE: alu.cond = alu.a >= alu.b;
            OP_LT: alu.cond = alu.a < alu.b;
            OP_ROTATE_RIGHT_CARRY: begin
                alu.result = {alu.carry_in, alu.a[3:1]}; // [RULE4]
                alu.carry_out = alu.a[0];
            end
            default: alu.result = NIB_ZERO;
        endcase
    end
endmodule

/* design/nalu_top.sv */
// Nibble ALU with operand latching, flag logic, skip control and APB registers
// Operation
// RULE1: Copy both operands into temporary registers before computing from them.
// RULE2: First operand is a 4-bit general register or memory nibble.
// RULE3: Second operand is a 4-bit memory nibble or immediate field.
// RULE4: Rotate right through carry uses only the addressed general register.
// RULE5: Arithmetic, logical and rotate results go back to the first operand.
// RULE6: True bit-check or compare stores nothing and turns next instruction into no-op.
// RULE7: Logical operations ignore no-store and decimal, keep carry and zero.
// RULE8: Every bit-check clears the no-store flag.
// RULE9: Index enable adds index register to operand addresses, except rotate.
// RULE10: Decimal flag picks binary or decimal; no-store suppresses arithmetic write-back.
// RULE11: Arithmetic ops come in register-memory and memory-immediate forms.
// RULE12: No-store 0 and decimal 0 give binary result stored at first operand.
// RULE13: Binary carry set on carry above 1111B or borrow below 0000B.
// RULE14: In store mode zero flag is set exactly when result is 0000B.
// RULE15: Carry and borrow forms use the carry flag in and rewrite it.
// RULE16: Carry and borrow share one carry flag.
// RULE17: Register-memory operations never write the second-operand memory nibble.
// RULE18: No-store mode writes nothing; zero kept on 0000B, cleared otherwise.
// RULE19: Decimal carry set above 1001B or below 0000B, else cleared.
// RULE20: Flags and write-back commit at the end of the execute cycle.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module nalu_top #(
    parameter int MEM_DEPTH = 128,
    parameter int ADDR_W = 7
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nalu_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core status
    output logic busy,
    output logic skip_next
);
    import nalu_pkg::*;

    if ((MEM_DEPTH > (1 << ADDR_W)) || (ADDR_W > CMD_FIELD_W) || (MEM_DEPTH < 1)
            || ((MEM_DEPTH * 4) > (4096 - 256))) begin : g_bad_params
        $error("nalu_top: memory depth or address width not supported");
    end

    function automatic logic in_window(input logic [11:0] a, input logic [11:0] base,
            input int count);
        logic [11:0] off;
        off = a - base;
        in_window = (a >= base) && (int'(off[11:2]) < count);
    endfunction

    nalu_state_e state;
    logic [31:0] cmd;
    logic [PSW_W-1:0] psw;
    logic [ADDR_W-1:0] index_reg;
    logic [3:0] temp_a;
    logic [3:0] temp_b;
    logic [3:0] last_result;
    logic skip_pending;
    logic [3:0] gen_reg [REG_COUNT];
    logic [3:0] data_mem [MEM_DEPTH];

    nalu_alu_if alu_bus ();

    nalu_core u_core (
        .alu(alu_bus.core)
    );

    // Command decode
    nalu_op_e op;
    logic form_imm;
    logic is_rot;
    logic idx_on;
    logic first_is_mem;
    logic [ADDR_W-1:0] first_mem_addr;
    logic [ADDR_W-1:0] second_mem_addr;
    logic [3:0] reg_sel;
    logic [3:0] fetch_a;
    logic [3:0] fetch_b;

    assign op = nalu_op_e'(cmd[CMD_OP_LSB +: 4]);
    assign form_imm = cmd[CMD_FORM_BIT];
    assign is_rot = op == OP_ROTATE_RIGHT_CARRY;
    assign idx_on = psw[PSW_INDEX_BIT] && !is_rot; // [RULE9]
    assign first_is_mem = form_imm && !is_rot; // [RULE4] [RULE11]
    assign reg_sel = cmd[CMD_FIRST_LSB +: 4];
    assign first_mem_addr = cmd[CMD_FIRST_LSB +: ADDR_W] + (idx_on ? index_reg : '0); // [RULE9]
    assign second_mem_addr = cmd[CMD_SECOND_LSB +: ADDR_W] + (idx_on ? index_reg : '0);
    assign fetch_a = first_is_mem ? data_mem[first_mem_addr] : gen_reg[reg_sel]; // [RULE2]

    always_comb begin
        if (is_rot) begin
            fetch_b = NIB_ZERO; // [RULE4]
        end else if (form_imm) begin
            fetch_b = cmd[CMD_SECOND_LSB +: 4]; // [RULE3]
        end else begin
            fetch_b = data_mem[second_mem_addr]; // [RULE3]
        end
    end

    // APB decode
    logic setup;
    logic access;
    logic hit_reg;
    logic hit_mem;
    logic mapped;
    logic cmd_take;
    logic wr_ok;
    logic [11:0] reg_off;
    logic [11:0] mem_off;
    logic [3:0] apb_reg_idx;
    logic [ADDR_W-1:0] apb_mem_idx;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_reg = in_window(paddr, OFF_REG_BASE, REG_COUNT);
    assign hit_mem = in_window(paddr, OFF_MEM_BASE, MEM_DEPTH);
    assign reg_off = paddr - OFF_REG_BASE;
    assign mem_off = paddr - OFF_MEM_BASE;
    assign apb_reg_idx = reg_off[5:2];
    assign apb_mem_idx = mem_off[ADDR_W+1:2];
    assign mapped = (paddr[1:0] == 2'b00) && ((paddr == OFF_CMD) || (paddr == OFF_PSW)
        || (paddr == OFF_INDEX) || (paddr == OFF_TEMP) || hit_reg || hit_mem);
    assign wr_ok = access && pwrite && !pslverr;
    assign cmd_take = wr_ok && (paddr == OFF_CMD);
    assign pready = 1'b1;
    assign busy = state != ST_IDLE;
    assign skip_next = skip_pending;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !mapped || (pwrite && (paddr == OFF_CMD) && busy)
                || (pwrite && (paddr == OFF_TEMP));
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
        end else if (setup && !pwrite) begin
            prdata <= '0;
            if (paddr == OFF_CMD) begin
                prdata <= cmd;
            end else if (paddr == OFF_PSW) begin
                prdata <= {25'h0, skip_pending, busy, psw};
            end else if (paddr == OFF_INDEX) begin
                prdata <= {{(32 - ADDR_W){1'b0}}, index_reg};
            end else if (paddr == OFF_TEMP) begin
                prdata <= {20'h0, last_result, temp_b, temp_a};
            end else if (hit_reg && (paddr[1:0] == 2'b00)) begin
                prdata <= {28'h0, gen_reg[apb_reg_idx]};
            end else if (hit_mem && (paddr[1:0] == 2'b00)) begin
                prdata <= {28'h0, data_mem[apb_mem_idx]};
            end
        end
    end

    // Sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_take && !skip_pending) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: state <= ST_EXEC;
                ST_EXEC: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmd <= CMD_RESET;
        end else if (cmd_take) begin
            cmd <= pwdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            index_reg <= '0;
        end else if (wr_ok && (paddr == OFF_INDEX)) begin
            index_reg <= pwdata[ADDR_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            temp_a <= NIB_ZERO;
            temp_b <= NIB_ZERO;
        end else if (state == ST_LOAD) begin
            temp_a <= fetch_a; // [RULE1]
            temp_b <= fetch_b; // [RULE1]
        end
    end

    // ALU hookup, computed from the temporary copies only
    assign alu_bus.op = op;
    assign alu_bus.a = temp_a; // [RULE1]
    assign alu_bus.b = temp_b;
    assign alu_bus.carry_in = psw[PSW_CARRY_BIT];
    assign alu_bus.decimal = psw[PSW_DECIMAL_BIT] && is_arith(op); // [RULE7] [RULE10]

    logic exec;
    logic zero_hit;
    logic wr_back;
    logic next_zero;

    assign exec = state == ST_EXEC;
    assign zero_hit = alu_bus.result == NIB_ZERO;
    assign wr_back = exec && (is_logic(op) || is_rot
        || (is_arith(op) && !psw[PSW_NOSTORE_BIT])); // [RULE5] [RULE7] [RULE10] [RULE12]
    assign next_zero = psw[PSW_NOSTORE_BIT] ? (psw[PSW_ZERO_BIT] && zero_hit)
        : zero_hit; // [RULE14] [RULE18]

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            last_result <= NIB_ZERO;
        end else if (exec) begin
            last_result <= alu_bus.result;
        end
    end

    // Status word: software write, then flag commit of the execute cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            psw <= PSW_RESET;
        end else begin
            if (wr_ok && (paddr == OFF_PSW)) begin
                psw <= pwdata[PSW_W-1:0];
            end
            if (exec && is_arith(op)) begin
                psw[PSW_CARRY_BIT] <= alu_bus.carry_out; // [RULE13] [RULE15] [RULE16] [RULE20]
                psw[PSW_ZERO_BIT] <= next_zero; // [RULE14] [RULE18] [RULE20]
            end
            if (exec && is_rot) begin
                psw[PSW_CARRY_BIT] <= alu_bus.carry_out; // [RULE4]
            end
            if (exec && is_bitchk(op)) begin
                psw[PSW_NOSTORE_BIT] <= 1'b0; // [RULE8]
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            skip_pending <= 1'b0;
        end else if (exec && is_check(op) && alu_bus.cond) begin
            skip_pending <= 1'b1; // [RULE6]
        end else if (cmd_take && skip_pending) begin
            skip_pending <= 1'b0; // [RULE6]
        end
    end

    // Nibble storage: bus writes, overridden by the write-back of the same cycle
    always_ff @(posedge core_clk) begin
        if (wr_ok && hit_reg) begin
            gen_reg[apb_reg_idx] <= pwdata[3:0];
        end
        if (wr_back && !first_is_mem) begin
            gen_reg[reg_sel] <= alu_bus.result; // [RULE5] [RULE20]
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_ok && hit_mem) begin
            data_mem[apb_mem_idx] <= pwdata[3:0];
        end
        if (wr_back && first_is_mem) begin
            data_mem[first_mem_addr] <= alu_bus.result; // [RULE5] [RULE17] [RULE20]
        end
    end

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    logic [3:0] mem_b_shadow;
    always_ff @(posedge core_clk) begin
        mem_b_shadow <= data_mem[second_mem_addr];
    end

    a_temp_load: assert property (state == ST_LOAD |=> temp_a == $past(fetch_a) // [RULE1]
        && temp_b == $past(fetch_b)) else $error("temporary operands not loaded");
    a_logic_flags: assert property (exec && is_logic(op) |=> psw[PSW_CARRY_BIT] // [RULE7]
        == $past(psw[PSW_CARRY_BIT]) && psw[PSW_ZERO_BIT] == $past(psw[PSW_ZERO_BIT])
        || $past(wr_ok)) else $error("logical op changed flags");
    a_bitchk_clear: assert property (exec && is_bitchk(op) // [RULE8]
        |=> !psw[PSW_NOSTORE_BIT]) else $error("bit check left no-store set");
    a_skip_set: assert property (exec && is_check(op) && alu_bus.cond // [RULE6]
        |=> skip_pending) else $error("skip not armed");
    a_check_nowrite: assert property (exec && is_check(op) |-> !wr_back) // [RULE6]
        else $error("check op wrote a result");
    a_nostore_nowrite: assert property (exec && is_arith(op) && psw[PSW_NOSTORE_BIT] // [RULE10]
        |-> !wr_back) else $error("no-store arithmetic wrote back");
    a_bin_carry: assert property (exec && is_arith(op) && !psw[PSW_DECIMAL_BIT] // [RULE13]
        && !wr_ok |=> psw[PSW_CARRY_BIT] == $past(alu_bus.carry_out))
        else $error("binary carry wrong");
    a_zero_store: assert property (exec && is_arith(op) && !psw[PSW_NOSTORE_BIT] // [RULE14]
        && !wr_ok |=> psw[PSW_ZERO_BIT] == ($past(alu_bus.result) == NIB_ZERO))
        else $error("zero flag wrong in store mode");
    a_zero_nostore: assert property (exec && is_arith(op) && psw[PSW_NOSTORE_BIT] // [RULE18]
        && !wr_ok && !zero_hit |=> !psw[PSW_ZERO_BIT])
        else $error("nonzero result kept zero flag");
    a_rot_carry: assert property (exec && is_rot && !wr_ok // [RULE4]
        |=> psw[PSW_CARRY_BIT] == $past(temp_a[0])) else $error("rotate carry wrong");
    a_second_kept: assert property (exec && !form_imm && !is_rot && !wr_ok // [RULE17]
        && (second_mem_addr != first_mem_addr || !first_is_mem)
        |=> data_mem[second_mem_addr] == mem_b_shadow)
        else $error("second operand changed");
    a_commit_time: assert property (cmd_take && !skip_pending && !busy // [RULE20]
        |=> state == ST_LOAD ##1 state == ST_EXEC ##1 state == ST_IDLE)
        else $error("execute sequence timing wrong");

    c_skip_used: cover property (skip_pending ##1 cmd_take ##1 !skip_pending);
    c_nostore_arith: cover property (exec && is_arith(op) && psw[PSW_NOSTORE_BIT]);
    c_dec_carry: cover property (exec && alu_bus.decimal && alu_bus.carry_out);
    c_cmd_refused: cover property (access && pwrite && (paddr == OFF_CMD) && pslverr);
endmodule

/* testbench/nalu_apb_host.sv */
// APB host model that issues register transfers to the nibble ALU
`timescale 1ns/100ps
module nalu_apb_host (
    // Clock
    input wire logic core_clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [nalu_pkg::PADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import nalu_pkg::*;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // Called just after a rising edge; holds the request until pready is sampled
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
endmodule

/* testbench/nibble_alu_binary_arith_tb_top.sv */
// Self-checking testbench of the nibble ALU
`timescale 1ns/100ps
module nibble_alu_binary_arith_tb_top;
    import nalu_pkg::*;
    logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, busy, skip_next;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic er;
    int failures, n_checks;
    logic [3:0] tbl_op [11] = '{OP_EQ, OP_EQ, OP_NE, OP_NE, OP_GE, OP_GE, OP_LT, OP_LT,
        OP_TEST_FALSE, OP_TEST_FALSE, OP_TEST_TRUE};
    logic [7:0] tbl_n [11] = '{8'h06, 8'h05, 8'h05, 8'h06, 8'h06, 8'h07, 8'h07, 8'h06,
        8'h09, 8'h02, 8'h07};
    logic tbl_skip [11] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
        1'b0};

    nalu_top #(.MEM_DEPTH(128), .ADDR_W(7)) u_nalu_top (.core_clk(core_clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
        .skip_next(skip_next));
    nalu_apb_host u_nalu_apb_host (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [11:0] ra(input int r);
        ra = OFF_REG_BASE + 12'(4 * r);
    endfunction
    function automatic logic [11:0] ma(input int i);
        ma = OFF_MEM_BASE + 12'(4 * i);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic re;
        u_nalu_apb_host.xfer(1'b1, a, d, rq, re);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] rq;
        logic re;
        u_nalu_apb_host.xfer(1'b0, a, 32'h0, rq, re);
        chk(nm, e, rq);
    endtask
    // Issues one command and waits for the block to go idle
    task automatic run(input logic [3:0] op, input logic f, input logic [7:0] a1,
                       input logic [7:0] a2);
        wr(OFF_CMD, {8'h00, a2, a1, 3'h0, f, op});
        do begin
            @(negedge core_clk);
        end while (busy !== 1'b0);
        @(posedge core_clk);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        test_done();
    end

    initial begin
        nrst = 1'b0;
        failures = 0;
        n_checks = 0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd(OFF_PSW, 32'h0, "psw");
        rd(OFF_INDEX, 32'h0, "index");
        rd(OFF_TEMP, 32'h0, "temp");
        $display("test reset done");
        // Binary add, both forms, carry chain
        wr(ra(1), 32'hF);
        wr(ma(1), 32'h1);
        run(OP_ADD, 1'b0, 8'h01, 8'h01);
        rd(ra(1), 32'h0, "r1");
        rd(ma(1), 32'h1, "m1");
        rd(OFF_PSW, 32'h6, "psw");
        rd(OFF_TEMP, 32'h01F, "temp");
        wr(ma(1), 32'hA);
        run(OP_ADD, 1'b1, 8'h01, 8'h05);
        rd(ma(1), 32'hF, "m1");
        rd(OFF_PSW, 32'h0, "psw");
        wr(ra(1), 32'h8);
        run(OP_ADD, 1'b1, 8'h01, 8'h01);
        run(OP_SUM_CARRY, 1'b0, 8'h01, 8'h01);
        rd(ra(1), 32'h9, "r1");
        rd(OFF_PSW, 32'h0, "psw");
        $display("test add done");
        // Binary subtract and borrow chain
        wr(ra(1), 32'h0);
        wr(ma(1), 32'h8);
        run(OP_SUB, 1'b0, 8'h01, 8'h01);
        rd(ra(1), 32'h8, "r1");
        rd(OFF_PSW, 32'h4, "psw");
        wr(ra(1), 32'h0);
        wr(ma(1), 32'h0);
        run(OP_SUB, 1'b1, 8'h01, 8'h01);
        run(OP_DIFF_BORROW, 1'b0, 8'h01, 8'h01);
        rd(ma(1), 32'hF, "m1");
        rd(ra(1), 32'h0, "r1");
        rd(OFF_PSW, 32'h6, "psw");
        $display("test sub done");
        // No-store mode
        wr(ra(1), 32'hF);
        wr(ma(1), 32'hF);
        wr(OFF_PSW, 32'h8);
        run(OP_ADD, 1'b0, 8'h01, 8'h01);
        rd(OFF_PSW, 32'hC, "psw");
        run(OP_SUB, 1'b0, 8'h01, 8'h01);
        rd(OFF_PSW, 32'h8, "psw");
        wr(OFF_PSW, 32'hA);
        run(OP_SUB, 1'b0, 8'h01, 8'h01);
        rd(OFF_PSW, 32'hA, "psw");
        rd(ra(1), 32'hF, "r1");
        $display("test nostore done");
        // Decimal mode
        wr(OFF_PSW, 32'h10);
        wr(ma(1), 32'h5);
        run(OP_ADD, 1'b1, 8'h01, 8'h07);
        rd(ma(1), 32'h2, "m1");
        rd(OFF_PSW, 32'h14, "psw");
        wr(ma(1), 32'h3);
        run(OP_ADD, 1'b1, 8'h01, 8'h04);
        rd(OFF_PSW, 32'h10, "psw");
        wr(ma(1), 32'h3);
        run(OP_SUB, 1'b1, 8'h01, 8'h05);
        rd(ma(1), 32'h8, "m1");
        rd(OFF_PSW, 32'h14, "psw");
        $display("test decimal done");
        // Logical ops keep flags and ignore no-store
        wr(OFF_PSW, 32'h1E);
        wr(ra(1), 32'hC);
        wr(ma(1), 32'hA);
        run(OP_AND, 1'b0, 8'h01, 8'h01);
        rd(ra(1), 32'h8, "r1");
        run(OP_OR, 1'b1, 8'h01, 8'h05);
        rd(ma(1), 32'hF, "m1");
        run(OP_XOR, 1'b0, 8'h01, 8'h01);
        rd(ra(1), 32'h7, "r1");
        rd(OFF_PSW, 32'h1E, "psw");
        $display("test logic done");
        // Bit test clears no-store and drops the next command
        wr(ma(1), 32'h6);
        run(OP_TEST_TRUE, 1'b1, 8'h01, 8'h06);
        chk("skip", 32'h1, {31'h0, skip_next});
        run(OP_XOR, 1'b1, 8'h01, 8'h0F);
        chk("skip", 32'h0, {31'h0, skip_next});
        rd(ma(1), 32'h6, "m1");
        rd(OFF_PSW, 32'h16, "psw");
        for (int k = 0; k < 11; k++) begin
            run(tbl_op[k], 1'b1, 8'h01, tbl_n[k]);
            chk("skip", {31'h0, tbl_skip[k]}, {31'h0, skip_next});
            if (tbl_skip[k]) begin
                run(OP_XOR, 1'b1, 8'h01, 8'h0F);
            end
            rd(ma(1), 32'h6, "m1");
        end
        rd(OFF_PSW, 32'h16, "psw");
        $display("test check done");
        // Rotate ignores index, index shifts memory addresses
        wr(OFF_PSW, 32'h5);
        wr(OFF_INDEX, 32'h3);
        wr(ra(2), 32'h3);
        run(OP_ROTATE_RIGHT_CARRY, 1'b0, 8'h02, 8'h00);
        rd(ra(2), 32'h9, "r2");
        rd(OFF_PSW, 32'h5, "psw");
        wr(OFF_PSW, 32'h1);
        wr(OFF_INDEX, 32'h2);
        wr(ma(3), 32'h4);
        run(OP_ADD, 1'b1, 8'h01, 8'h01);
        rd(ma(3), 32'h5, "m3");
        rd(ma(1), 32'h6, "m1");
        $display("test index done");
        // Refused accesses
        wr(OFF_PSW, 32'h0);
        u_nalu_apb_host.xfer(1'b0, 12'hFFC, 32'h0, q, er);
        chk("unmapped", 32'h1, {31'h0, er});
        u_nalu_apb_host.xfer(1'b1, OFF_TEMP, 32'h0, q, er);
        chk("temp write", 32'h1, {31'h0, er});
        wr(OFF_CMD, 32'h0001_0110);
        chk("busy", 32'h1, {31'h0, busy});
        u_nalu_apb_host.xfer(1'b1, OFF_CMD, 32'h0001_0110, q, er);
        chk("cmd busy", 32'h1, {31'h0, er});
        repeat (4) @(posedge core_clk);
        rd(ma(1), 32'h7, "m1");
        $display("test refuse done");
        test_done();
    end
endmodule
